// ==== design/coef_bank_consts.vh ====
// Register indices and reset values for the loop filter coefficient bank
`ifndef COEF_BANK_CONSTS_VH
`define COEF_BANK_CONSTS_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_CHAN_A_NORMAL_LF_GAIN 16'hfe2c
`define IDX_CHAN_B_NORMAL_LF_GAIN 16'hfe2d
`define IDX_CHAN_A_NORMAL_ZERO 16'hfe2e
`define IDX_CHAN_B_NORMAL_ZERO 16'hfe2f
`define IDX_CHAN_A_NORMAL_POLE 16'hfe30
`define IDX_CHAN_B_NORMAL_POLE 16'hfe31
`define IDX_CHAN_A_NORMAL_HF_GAIN 16'hfe32
`define IDX_CHAN_B_NORMAL_HF_GAIN 16'hfe33
`define IDX_CHAN_A_LIGHT_LF_GAIN 16'hfe34
`define IDX_CHAN_B_LIGHT_LF_GAIN 16'hfe35
`define IDX_CHAN_A_LIGHT_ZERO 16'hfe36
`define IDX_CHAN_B_LIGHT_ZERO 16'hfe37
`define IDX_CHAN_A_LIGHT_POLE 16'hfe38
`define IDX_CHAN_B_LIGHT_POLE 16'hfe39
`define IDX_CHAN_A_LIGHT_HF_GAIN 16'hfe3a
`define IDX_CHAN_B_LIGHT_HF_GAIN 16'hfe3b
`define IDX_CHAN_A_MOD_LIMIT 16'hfe3c
`define IDX_CHAN_B_MOD_LIMIT 16'hfe3d
`define IDX_MODE_STATUS 16'hfe3f

// ****************************************
// Slot offsets inside the bank (slot = index - first index)
// ****************************************
`define SLOT_NORMAL_LF 5'h00
`define SLOT_NORMAL_ZERO 5'h02
`define SLOT_NORMAL_POLE 5'h04
`define SLOT_NORMAL_HF 5'h06
`define SLOT_LIGHT_LF 5'h08
`define SLOT_LIGHT_ZERO 5'h0a
`define SLOT_LIGHT_POLE 5'h0c
`define SLOT_LIGHT_HF 5'h0e
`define SLOT_MOD_LIMIT 5'h10
`define NUM_SLOTS 18

// ****************************************
// Reset values and field positions
// ****************************************
`define COEF_RESET 8'h00
`define STATUS_LIGHT_A_BIT 0
`define STATUS_LIGHT_B_BIT 1

`endif

// ==== design/loop_filter_coefficient_bank.v ====
// Coefficient register bank and mode selection for two channels
`timescale 1ns/100ps
`default_nettype none
`include "coef_bank_consts.vh"

module loop_filter_coefficient_bank #(
    parameter ADDR_W = 18
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Operating mode per channel
    input wire light_load_a,
    input wire light_load_b,
    // Coefficients applied to channel A
    output reg [7:0] chan_a_lf_gain,
    output reg [7:0] chan_a_zero,
    output reg [7:0] chan_a_pole,
    output reg [7:0] chan_a_hf_gain,
    output reg [7:0] chan_a_mod_limit,
    // Coefficients applied to channel B
    output reg [7:0] chan_b_lf_gain,
    output reg [7:0] chan_b_zero,
    output reg [7:0] chan_b_pole,
    output reg [7:0] chan_b_hf_gain,
    output reg [7:0] chan_b_mod_limit
);

    // ****************************************
    // Address decode
    // ****************************************
    // Returns {hit, slot}; misaligned or foreign words miss
    function [5:0] decode;
        input [ADDR_W-1:0] addr;
        reg [15:0] idx;
        reg [15:0] off;
        begin
            idx = addr[17:2];
            off = idx - `IDX_CHAN_A_NORMAL_LF_GAIN;
            if (addr[1:0] != 2'h0) begin
                decode = 6'h00;
            end else if (idx >= `IDX_CHAN_A_NORMAL_LF_GAIN &&
                         idx <= `IDX_CHAN_B_MOD_LIMIT) begin
                decode = {1'b1, off[4:0]};
            end else begin
                decode = 6'h00;
            end
        end
    endfunction

    // Picks the light or normal slot of one channel
    function [4:0] pick;
        input light;
        input [4:0] light_slot;
        input [4:0] normal_slot;
        input chan;
        begin
            pick = (light ? light_slot : normal_slot) | {4'h0, chan};
        end
    endfunction

    reg [7:0] coef [0:`NUM_SLOTS-1];
    wire [5:0] dec;
    wire hit;
    wire is_status;
    wire setup;
    wire access;
    integer i;

    assign dec = decode(paddr);
    assign hit = dec[5];
    assign is_status = (paddr[1:0] == 2'h0) &&
                       (paddr[17:2] == `IDX_MODE_STATUS);
    assign setup = psel && !penable;
    assign access = psel && penable && pready;

    // ****************************************
    // APB answer: one wait-free access phase
    // ****************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            if (setup) begin
                // Status is read-only, so a write to it errs
                pslverr <= !(hit || (is_status && !pwrite));
                if (!pwrite && hit) begin
                    prdata <= {24'h00_0000, coef[dec[4:0]]};
                end else if (!pwrite && is_status) begin
                    prdata <= {30'h0000_0000, light_load_b,
                               light_load_a};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ****************************************
    // Coefficient storage
    // ****************************************
    // Only the addressed slot changes, so channels never cross
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
                coef[i] <= `COEF_RESET;
            end
        end else if (access && pwrite && hit && pstrb[0]) begin
            coef[dec[4:0]] <= pwdata[7:0];
        end
    end

    // ****************************************
    // Mode selection toward the filter
    // ****************************************
    // Registered so all ten outputs move on the same edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chan_a_lf_gain <= `COEF_RESET;
            chan_a_zero <= `COEF_RESET;
            chan_a_pole <= `COEF_RESET;
            chan_a_hf_gain <= `COEF_RESET;
            chan_a_mod_limit <= `COEF_RESET;
            chan_b_lf_gain <= `COEF_RESET;
            chan_b_zero <= `COEF_RESET;
            chan_b_pole <= `COEF_RESET;
            chan_b_hf_gain <= `COEF_RESET;
            chan_b_mod_limit <= `COEF_RESET;
        end else begin
            chan_a_lf_gain <= coef[pick(light_load_a, `SLOT_LIGHT_LF,
                `SLOT_NORMAL_LF, 1'b0)];
            chan_a_zero <= coef[pick(light_load_a, `SLOT_LIGHT_ZERO,
                `SLOT_NORMAL_ZERO, 1'b0)];
            chan_a_pole <= coef[pick(light_load_a, `SLOT_LIGHT_POLE,
                `SLOT_NORMAL_POLE, 1'b0)];
            chan_a_hf_gain <= coef[pick(light_load_a, `SLOT_LIGHT_HF,
                `SLOT_NORMAL_HF, 1'b0)];
            chan_a_mod_limit <= coef[`SLOT_MOD_LIMIT];
            chan_b_lf_gain <= coef[pick(light_load_b, `SLOT_LIGHT_LF,
                `SLOT_NORMAL_LF, 1'b1)];
            chan_b_zero <= coef[pick(light_load_b, `SLOT_LIGHT_ZERO,
                `SLOT_NORMAL_ZERO, 1'b1)];
            chan_b_pole <= coef[pick(light_load_b, `SLOT_LIGHT_POLE,
                `SLOT_NORMAL_POLE, 1'b1)];
            chan_b_hf_gain <= coef[pick(light_load_b, `SLOT_LIGHT_HF,
                `SLOT_NORMAL_HF, 1'b1)];
            chan_b_mod_limit <= coef[`SLOT_MOD_LIMIT + 5'h01];
        end
    end

endmodule
`default_nettype wire

// ==== bench/coef_bank_properties.sv ====
// Port checker for the coefficient bank
`timescale 1ns/100ps
`default_nettype none
module coef_bank_props #(parameter ADDR_W = 18) (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Mode and applied coefficients
    input wire logic light_load_a,
    input wire logic light_load_b,
    input wire logic [7:0] chan_a_lf_gain,
    input wire logic [7:0] chan_a_zero,
    input wire logic [7:0] chan_a_pole,
    input wire logic [7:0] chan_a_hf_gain,
    input wire logic [7:0] chan_a_mod_limit,
    input wire logic [7:0] chan_b_pole
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic setup;
    logic wr;
    assign setup = psel && !penable;
    assign wr = pready && pwrite;
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    read_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    misalign_err_a: assert property (setup && paddr[1:0] != 0 |=> pslverr)
        else $error("misaligned access not refused");
    reset_zero_a: assert property ($rose(nrst) |-> chan_a_pole == 8'h00)
        else $error("coefficient not cleared by reset");
    a_isolated_a: assert property (wr && paddr[17:2] == 16'hfe31
        && $stable(light_load_a) |=> $stable(chan_a_pole))
        else $error("channel b write moved channel a");
    b_isolated_a: assert property (wr && paddr[17:2] == 16'hfe30
        && $stable(light_load_b) |=> $stable(chan_b_pole))
        else $error("channel a write moved channel b");
    limit_mode_free_a: assert property ($changed(light_load_a) && !psel
        |=> $stable(chan_a_mod_limit))
        else $error("limit follows mode");
    coef_hold_a: assert property (!psel && $past(!psel)
        && $stable(light_load_a) |=> $stable({chan_a_lf_gain, chan_a_zero,
        chan_a_pole, chan_a_hf_gain}))
        else $error("coefficient moved while idle");
    cover property (wr);
    cover property (pready && pslverr);
    cover property ($rose(light_load_a));
endmodule
bind loop_filter_coefficient_bank coef_bank_props #(.ADDR_W(ADDR_W)) props (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .light_load_a(light_load_a),
    .light_load_b(light_load_b), .chan_a_lf_gain(chan_a_lf_gain),
    .chan_a_zero(chan_a_zero), .chan_a_pole(chan_a_pole),
    .chan_a_hf_gain(chan_a_hf_gain), .chan_a_mod_limit(chan_a_mod_limit),
    .chan_b_pole(chan_b_pole));
`default_nettype wire

// ==== bench/loop_filter_coefficient_bank_bench.sv ====
// Self-checking bench for the coefficient bank
`timescale 1ns/100ps
`default_nettype none
module loop_filter_coefficient_bank_bench;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic light_load_a = 0, light_load_b = 0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0, prdata, got;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, err;
    wire [7:0] c [0:9];
    integer n_mismatch = 0, cmp_count = 0, i, m;
    loop_filter_coefficient_bank dut (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .light_load_a(light_load_a), .light_load_b(light_load_b),
        .chan_a_lf_gain(c[0]), .chan_a_zero(c[1]), .chan_a_pole(c[2]),
        .chan_a_hf_gain(c[3]), .chan_a_mod_limit(c[4]),
        .chan_b_lf_gain(c[5]), .chan_b_zero(c[6]), .chan_b_pole(c[7]),
        .chan_b_hf_gain(c[8]), .chan_b_mod_limit(c[9]));
    initial forever #5 clk = ~clk;
    // Distinct code per register so crossed wiring shows
    function automatic logic [7:0] v(input logic [15:0] x);
        v = x[7:0] ^ 8'h5a;
    endfunction
    function automatic logic [39:0] exp_set(input int ch, input logic l);
        logic [15:0] b;
        b = (l ? 16'hfe34 : 16'hfe2c) + ch[15:0];
        exp_set = {v(b), v(b + 2), v(b + 4), v(b + 6), v(16'hfe3c + ch)};
    endfunction
    task automatic chk(input string nm, input logic [39:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a,
        input logic [31:0] d, input logic [3:0] s);
        integer k;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) n_mismatch++;
        got = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        for (i = 'hfe2c; i <= 'hfe3d; i++) begin
            apb(0, {i[15:0], 2'b00}, 32'h0, 4'hf);
            chk("reset value", {err, got}, 0);
        end
        for (i = 'hfe2c; i <= 'hfe3d; i++)
            apb(1, {i[15:0], 2'b00}, {24'hffffff, v(i[15:0])}, 4'hf);
        for (i = 'hfe2c; i <= 'hfe3d; i++) begin
            apb(0, {i[15:0], 2'b00}, 32'h0, 4'hf);
            chk("readback", {err, got}, {1'b0, 24'h0, v(i[15:0])});
        end
        $display("test registers done");
        for (m = 0; m < 4; m++) begin
            light_load_a <= m[0];
            light_load_b <= m[1];
            repeat (3) @(posedge clk);
            chk("set a", {c[0], c[1], c[2], c[3], c[4]}, exp_set(0, m[0]));
            chk("set b", {c[5], c[6], c[7], c[8], c[9]}, exp_set(1, m[1]));
        end
        apb(1, {16'hfe38, 2'b00}, 32'h000000a5, 4'hf);
        repeat (3) @(posedge clk);
        chk("poles", {c[2], c[7]}, {8'ha5, v(16'hfe39)});
        $display("test modes done");
        apb(0, {16'hfe3e, 2'b00}, 32'h0, 4'hf);
        chk("unmapped", {err, got}, {1'b1, 32'h0});
        apb(0, {16'hfe3f, 2'b00}, 32'h0, 4'hf);
        chk("status read", {err, got}, {1'b0, 32'h3});
        apb(1, {16'hfe3f, 2'b00}, 32'h0, 4'hf);
        chk("status write", err, 1);
        apb(0, {16'hfe2c, 2'b01}, 32'h0, 4'hf);
        chk("misaligned", {err, got}, {1'b1, 32'h0});
        apb(1, {16'hfe2c, 2'b00}, 32'h00000011, 4'he);
        apb(0, {16'hfe2c, 2'b00}, 32'h0, 4'hf);
        chk("strobe off", got, v(16'hfe2c));
        $display("test refusals done");
        final_report;
    end
endmodule
`default_nettype wire
